// file: rtl/roak_pkg.sv
package roak_pkg;
    // =====================================================================
    // timing, in nanoseconds as given and in 50 MHz clock cycles
    localparam int CLK_PERIOD_NS     = 20;
    localparam int AS_SETTLE_NS      = 25;
    localparam int AS_VECTOR_NS      = 50;
    localparam int ACK_SETUP_NS      = 25;
    localparam int IACKOUT_RELEASE_NS = 30;
    // least times round up to whole cycles
    localparam int CYC_SETTLE  = (AS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_VECTOR  = (AS_VECTOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_ACK_REQ = (ACK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // decision waits a second settle time after capture and never less than 50 ns
    localparam int CYC_DECIDE  = (CYC_VECTOR > 2 * CYC_SETTLE) ? CYC_VECTOR : 2 * CYC_SETTLE;

    // =====================================================================
    // reset values and field layout
    localparam logic       IACKOUT_RST = 1'b1;
    localparam logic       OE_OFF      = 1'b1;
    localparam logic [7:0] DATA_RST    = 8'h00;
    localparam logic [6:0] IRQ_OE_RST  = 7'h7F;
    localparam int         LEVEL_W     = 3;

    typedef logic [LEVEL_W-1:0] level_t;

    // acknowledge cycle sequencer
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_DECIDE = 3'b010,
        ST_PASS   = 3'b011,
        ST_VECTOR = 3'b100,
        ST_HOLD   = 3'b101
    } cycle_state_t;
endpackage

// file: rtl/port_link_if.sv
`timescale 1ns/1ps
// signals between the acknowledge sequencer and one port's interrupter
interface port_link_if;
    import roak_pkg::*;
    level_t level;      // acknowledged level from A03..A01
    logic   iack_cycle; // cycle is an interrupt acknowledge
    logic   capture;    // settle-delayed strobe, one cycle
    logic   answer_ok;  // all shared conditions to put out the vector
    logic   end_cycle;  // handler has released DS0*
    logic   as_idle;    // address strobe released
    logic   blocked;    // higher-ranked port answers this cycle
    logic   match_q;
    logic   vec_en;
    logic   pending;

    modport core (output level, iack_cycle, capture, answer_ok, end_cycle, as_idle, blocked,
                  input match_q, vec_en, pending);
    modport port (input level, iack_cycle, capture, answer_ok, end_cycle, as_idle, blocked,
                  output match_q, vec_en, pending);
endinterface

// file: rtl/port_interrupter.sv
`timescale 1ns/1ps
module port_interrupter (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              int_req,
    input  wire roak_pkg::level_t  prio,
    port_link_if.port              link
);
    import roak_pkg::*;

    logic served_reg;
    logic match_reg;
    logic vec_en_reg;
    logic cmp_eq;

    // =====================================================================
    // request bookkeeping
    // served stays set while the chip keeps its line up, so one event
    // raises exactly one request; status read drops the line and rearms
    assign link.pending = int_req && !served_reg; // see R18
    assign cmp_eq       = (link.level == prio) && link.iack_cycle && link.pending;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            served_reg <= 1'b0; // see R16
        end else if (vec_en_reg && link.end_cycle) begin
            served_reg <= 1'b1; // see R10
        end else if (!int_req) begin
            served_reg <= 1'b0; // see R14
        end
    end

    // comparison captured on the settle-delayed strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            match_reg <= 1'b0;
        end else if (link.as_idle) begin
            match_reg <= 1'b0;
        end else if (link.capture) begin
            match_reg <= cmp_eq; // see R02, R04
        end
    end

    // vector enable latched once, held until DS0* rises
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vec_en_reg <= 1'b0;
        end else if (vec_en_reg) begin
            vec_en_reg <= !link.end_cycle; // see R09
        end else begin
            vec_en_reg <= match_reg && !link.blocked && link.answer_ok; // see R06, R03
        end
    end

    assign link.match_q = match_reg;
    assign link.vec_en  = vec_en_reg;

    // =====================================================================
    // checks
    a_compare_capture: assert property (@(posedge clock) disable iff (!rst_n) // see R02
        link.capture |=> (match_reg == $past(cmp_eq)))
        else $error("match flag does not hold the captured comparison");
    a_vector_needs_match: assert property (@(posedge clock) disable iff (!rst_n) // see R06
        $rose(vec_en_reg) |-> $past(match_reg) && $past(link.answer_ok))
        else $error("vector enable rose without a captured match");
endmodule

// file: rtl/vme_roak_interrupter.sv
`timescale 1ns/1ps
// Function
// R01: a raised controller interrupt pulls the port's IRQ line low at once; here it is pulled on the third clock edge after that, 40 to 60 ns.
// R02: in acknowledge cycles each port compares A03..A01 with its priority.
// R03: one interrupter per port; on equal priority port A answers first.
// R04: the comparison is captured on the strobe delayed 25 ns.
// R05: a further 25 ns passes before passing on or answering.
// R06: a matching port latches vector enable after IACKIN, DS0, 50 ns, DTACK free.
// R07: vector enable drives the switch-set status/ID byte onto the data lines.
// R08: vector enable requests DTACK through a 25 ns delayed acknowledge request.
// R09: vector enable holds until DS0* rises; its fall releases the IRQ line.
// R10: controller interrupt stays up until the handler reads its status register.
// R11: DTACK releases only with driver off, interrupter ack idle, DS1* high.
// R12: with no matching port, IACKOUT* goes low after IACKIN and delayed strobe.
// R13: IACKOUT* releases within 30 ns after the address strobe rises; here it releases on the third clock edge after that, 40 to 60 ns.
// R14: reading an event status register clears it whole.
// R15: DTACK asserts on either acknowledge, releases when both idle and strobes high.
// R16: system reset initialises the interrupter and timing logic.
// R17: each strobe delay is a whole number of clocks, never shorter.
// R18: a port answers with its vector only while its own request is pending.
module vme_roak_interrupter #(
    parameter int AS_CNT_W = 3
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             as_n,
    input  wire logic             ds0_n,
    input  wire logic             ds1_n,
    input  wire logic             iack_n,
    input  wire logic             iackin_n,
    input  wire logic             dtack_n,
    input  wire roak_pkg::level_t addr,
    input  wire logic             int_a,
    input  wire logic             int_b,
    input  wire roak_pkg::level_t prio_a,
    input  wire roak_pkg::level_t prio_b,
    input  wire logic [7:0]       status_id_a,
    input  wire logic [7:0]       status_id_b,
    input  wire logic             rw_ack_n,
    input  wire logic             rw_den_n,
    output logic                  iackout_n,
    output logic [7:1]            irq_o,
    output logic [7:1]            irq_oe_n,
    output logic                  dtack_o,
    output logic                  dtack_oe_n,
    output logic [7:0]            data_o,
    output logic                  data_oe_n,
    output logic                  data_driver_enable_n
);
    import roak_pkg::*;

    localparam int SYNC_W = 6 + 2 * LEVEL_W + LEVEL_W + 2 + 16;
    localparam int ACK_D  = CYC_ACK_REQ;
    localparam int CAP_D  = CYC_SETTLE - 1;

    if (CYC_DECIDE >= (1 << AS_CNT_W)) begin : g_check
        $error("strobe delay counter too narrow");
    end

    // =====================================================================
    // pin synchronisers: every bus and switch input passes two flops
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic              as_s, ds0_s, ds1_s, iack_s, iackin_s, dtack_s;
    level_t            addr_s, prio_a_s, prio_b_s;
    logic              int_a_n_s, int_b_n_s;
    logic [7:0]        status_a_s, status_b_s;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
        end else begin
            sync1_reg <= {as_n, ds0_n, ds1_n, iack_n, iackin_n, dtack_n, addr, prio_a, prio_b,
                          !int_a, !int_b, status_id_a, status_id_b};
            sync2_reg <= sync1_reg;
        end
    end

    // interrupt pins are carried inverted so reset reads as "no request"
    assign {as_s, ds0_s, ds1_s, iack_s, iackin_s, dtack_s, addr_s, prio_a_s, prio_b_s,
            int_a_n_s, int_b_n_s, status_a_s, status_b_s} = sync2_reg;

    // =====================================================================
    // address strobe delay line as a saturating cycle count
    logic [AS_CNT_W-1:0] as_cnt_reg;
    cycle_state_t        state_reg;
    cycle_state_t        state_next;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            as_cnt_reg <= '0;
        end else if (as_s) begin
            as_cnt_reg <= '0;
        end else if (as_cnt_reg < AS_CNT_W'(CYC_DECIDE)) begin
            as_cnt_reg <= as_cnt_reg + 1'b1; // see R17
        end
    end

    // =====================================================================
    // ports: one interrupter each, port A ranks above port B
    port_link_if pa ();
    port_link_if pb ();
    logic any_match;
    logic answer_ok;
    logic vec_any;

    assign any_match = pa.match_q || pb.match_q;
    assign vec_any   = pa.vec_en || pb.vec_en;
    assign answer_ok = (state_reg == ST_DECIDE) && !iackin_s && !ds0_s && dtack_s; // see R06

    assign pa.level      = addr_s;
    assign pa.iack_cycle = !iack_s;
    assign pa.capture    = (state_reg == ST_SETTLE) && (as_cnt_reg == AS_CNT_W'(CYC_SETTLE));
    assign pa.answer_ok  = answer_ok;
    assign pa.end_cycle  = ds0_s;
    assign pa.as_idle    = as_s;
    assign pa.blocked    = 1'b0;
    assign pb.level      = addr_s;
    assign pb.iack_cycle = !iack_s;
    assign pb.capture    = pa.capture;
    assign pb.answer_ok  = answer_ok;
    assign pb.end_cycle  = ds0_s;
    assign pb.as_idle    = as_s;
    assign pb.blocked    = pa.match_q; // see R03

    port_interrupter u_port_a (
        .clock   (clock),
        .rst_n   (rst_n),
        .int_req (!int_a_n_s), // see R01
        .prio    (prio_a_s),
        .link    (pa.port)
    );
    port_interrupter u_port_b (
        .clock   (clock),
        .rst_n   (rst_n),
        .int_req (!int_b_n_s), // see R01
        .prio    (prio_b_s),
        .link    (pb.port)
    );

    // =====================================================================
    // acknowledge cycle sequencer; AS* release ends every cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:   if (!as_s) state_next = ST_SETTLE;
            ST_SETTLE: if (as_cnt_reg >= AS_CNT_W'(CYC_DECIDE)) state_next = ST_DECIDE; // see R05
            ST_DECIDE: begin
                if (any_match && answer_ok) begin
                    state_next = ST_VECTOR;
                end else if (!any_match && !iackin_s && !iack_s) begin
                    state_next = ST_PASS; // see R12
                end
            end
            ST_PASS:   state_next = ST_PASS;
            ST_VECTOR: if (ds0_s) state_next = ST_HOLD;
            ST_HOLD:   state_next = ST_HOLD;
            default:   state_next = ST_IDLE;
        endcase
        if (as_s) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE; // see R16
        end else begin
            state_reg <= state_next;
        end
    end

    // daisy chain pass-on, dropped as soon as AS* is seen high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            iackout_n <= IACKOUT_RST;
        end else begin
            iackout_n <= !(state_next == ST_PASS); // see R12, R13
        end
    end

    // =====================================================================
    // IRQ lines: each port pulls the line its priority names
    // the line stays pulled through the vector; served, set as vector
    // enable falls, is what lets it go (release on acknowledge)
    logic req_a, req_b;
    assign req_a = pa.pending; // see R09
    assign req_b = pb.pending; // see R09

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_oe_n <= IRQ_OE_RST;
            irq_o    <= '0;
        end else begin
            for (int i = 1; i <= 7; i++) begin
                irq_oe_n[i] <= !((req_a && prio_a_s == LEVEL_W'(i)) ||
                                 (req_b && prio_b_s == LEVEL_W'(i))); // see R01, R09
            end
            irq_o <= '0;
        end
    end

    // =====================================================================
    // status/ID drive and delayed acknowledge request
    logic [AS_CNT_W-1:0] ack_cnt_reg;
    logic                vector_ack_request_n;
    logic                interrupter_ack_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_oe_n <= OE_OFF;
            data_o    <= DATA_RST;
        end else begin
            data_oe_n <= !vec_any; // see R07
            data_o    <= pa.vec_en ? status_a_s : (pb.vec_en ? status_b_s : DATA_RST);
        end
    end

    // gives the byte at least 25 ns of setup before DTACK* falls
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_cnt_reg <= '0;
        end else if (!vec_any) begin
            ack_cnt_reg <= '0;
        end else if (ack_cnt_reg < AS_CNT_W'(CYC_ACK_REQ)) begin
            ack_cnt_reg <= ack_cnt_reg + 1'b1;
        end
    end

    assign vector_ack_request_n = !(vec_any && ack_cnt_reg >= AS_CNT_W'(CYC_ACK_REQ));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            interrupter_ack_n <= 1'b1;
        end else begin
            interrupter_ack_n <= vector_ack_request_n; // see R08
        end
    end

    // =====================================================================
    // DTACK* assert and release, shared with the read/write machine
    logic den_n;
    assign den_n = data_oe_n && rw_den_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dtack_oe_n           <= OE_OFF;
            dtack_o              <= 1'b0;
            data_driver_enable_n <= OE_OFF;
        end else begin
            data_driver_enable_n <= den_n;
            dtack_o              <= 1'b0;
            if (!rw_ack_n || !interrupter_ack_n) begin
                dtack_oe_n <= 1'b0; // see R15
            end else if (den_n && ds0_s && ds1_s) begin
                dtack_oe_n <= OE_OFF; // see R11, R15
            end
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_vec_start;
        $rose(vec_any);
    endsequence
    sequence s_ack_delayed;
        interrupter_ack_n [*3] ##1 !interrupter_ack_n;
    endsequence

    a_irq_follows_int: assert property ((req_a && prio_a_s != '0) |=> // see R01
        !irq_oe_n[$past(prio_a_s)])
        else $error("port A request did not pull its IRQ line");
    a_port_a_first: assert property (!(pa.vec_en && pb.vec_en)) // see R03
        else $error("both ports drove a vector");
    a_capture_time: assert property ((state_reg == ST_SETTLE && // see R04
        $past(state_reg) == ST_IDLE) |-> ##CAP_D pa.capture)
        else $error("capture strobe off its delay");
    a_decide_wait: assert property ($fell(iackout_n) |-> // see R05
        $past(as_cnt_reg) >= AS_CNT_W'(CYC_DECIDE))
        else $error("chain passed before the decision delay");
    a_vector_hold: assert property ((vec_any && !ds0_s) |=> vec_any) // see R09
        else $error("vector enable dropped before DS0 release");
    a_data_drive: assert property (pa.vec_en |=> !data_oe_n && data_o == $past(status_a_s)) // see R07
        else $error("status/ID byte not driven");
    a_ack_delay: assert property (s_vec_start |-> s_ack_delayed) // see R08
        else $error("acknowledge request not delayed by setup time");
    a_dtack_release: assert property ($rose(dtack_oe_n) |-> // see R11
        $past(den_n) && $past(ds1_s) && $past(interrupter_ack_n))
        else $error("DTACK released too early");
    a_iackout_release: assert property (as_s |=> iackout_n) // see R13
        else $error("IACKOUT not released after AS");
    a_pass_chain: assert property ((state_reg == ST_DECIDE && !any_match && !iackin_s // see R12
        && !iack_s && !as_s) |=> !iackout_n)
        else $error("unmatched acknowledge not passed on");
    a_ack_spacing: assert property (s_vec_start |-> ##ACK_D vec_any || ds0_s) // see R08
        else $error("vector enable ended during setup");
endmodule

// file: sim/vme_iack_master.sv
`timescale 1ns/1ps
// =====================================================================
// interrupt handler side: one acknowledge cycle per call of ack_cycle
module vme_iack_master (
    input  wire logic              clock,
    input  wire logic              dtack_n,
    input  wire logic              iackout_n,
    output logic                   as_n,
    output logic                   ds0_n,
    output logic                   ds1_n,
    output logic                   iack_n,
    output logic                   iackin_n,
    output roak_pkg::level_t       addr
);
    import roak_pkg::*;

    // strobes idle, chain input released from time zero
    initial begin
        {as_n, ds0_n, ds1_n, iack_n, iackin_n} = 5'h1F;
        addr = 3'h0;
    end

    // hold keeps DS0* low after the answer so an early DTACK* release is seen
    task automatic ack_cycle(input level_t lvl, input int hold,
                             output logic acked, output logic early);
        int n;
        acked = 1'b0;
        early = 1'b0;
        @(posedge clock);
        #1;
        addr = lvl;
        {as_n, ds0_n, ds1_n, iack_n, iackin_n} = 5'h00;
        // bounded wait for a vector answer or a pass-on
        n = 0;
        while (dtack_n && iackout_n && n < 40) begin
            @(posedge clock);
            n++;
        end
        acked = !dtack_n;
        repeat (hold) begin
            @(posedge clock);
            if (acked && dtack_n) early = 1'b1;
        end
        #1;
        {ds0_n, ds1_n} = 2'b11;
        n = 0;
        while (!dtack_n && n < 20) begin
            @(posedge clock);
            n++;
        end
        #1;
        {as_n, iack_n, iackin_n} = 3'h7;
        addr = ~lvl; // released lines carry no valid level
        repeat (3) @(posedge clock); // strobe high at least two clocks
        #1; // outputs of the last edge have settled before the caller looks
    endtask
endmodule

// file: sim/test_vme_roak_interrupter.sv
`timescale 1ns/1ps
module test_vme_roak_interrupter;
    import roak_pkg::*;

    // =====================================================================
    // stimulus and observed signals
    logic          clock       = 1'b0;
    logic          rst_n       = 1'b0;
    logic          int_a       = 1'b0;
    logic          int_b       = 1'b0;
    logic          rw_ack_n    = 1'b1;
    logic          rw_den_n    = 1'b1;
    level_t        prio_a      = 3'h1;
    level_t        prio_b      = 3'h2;
    logic [7:0]    status_id_a = 8'h00;
    logic [7:0]    status_id_b = 8'h00;
    logic          as_n, ds0_n, ds1_n, iack_n, iackin_n;
    level_t        addr;
    logic          iackout_n, dtack_o, dtack_oe_n, data_oe_n, data_driver_enable_n;
    logic [7:1]    irq_o, irq_oe_n;
    logic [7:0]    data_o;
    wire           dtack_n = dtack_oe_n ? 1'b1 : dtack_o; // pulled up when free
    logic          acked, early;
    logic          data_oe_p   = 1'b1;
    logic          iackout_p   = 1'b1;
    logic [10:0]   got;
    logic [10:0]   exp_q[$];
    int            fails       = 0;
    int            tests_run   = 0;
    localparam logic [10:0] PASS_ON = 11'h1FF;

    always #10 clock = ~clock;

    vme_roak_interrupter uut (
        .clock(clock), .rst_n(rst_n), .as_n(as_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
        .iack_n(iack_n), .iackin_n(iackin_n), .dtack_n(dtack_n), .addr(addr),
        .int_a(int_a), .int_b(int_b), .prio_a(prio_a), .prio_b(prio_b),
        .status_id_a(status_id_a), .status_id_b(status_id_b), .rw_ack_n(rw_ack_n),
        .rw_den_n(rw_den_n), .iackout_n(iackout_n), .irq_o(irq_o), .irq_oe_n(irq_oe_n),
        .dtack_o(dtack_o), .dtack_oe_n(dtack_oe_n), .data_o(data_o),
        .data_oe_n(data_oe_n), .data_driver_enable_n(data_driver_enable_n)
    );

    vme_iack_master bus (
        .clock(clock), .dtack_n(dtack_n), .iackout_n(iackout_n), .as_n(as_n),
        .ds0_n(ds0_n), .ds1_n(ds1_n), .iack_n(iack_n), .iackin_n(iackin_n), .addr(addr)
    );

    // =====================================================================
    // checking and closing
    task automatic check(input logic [10:0] value, input logic [10:0] want);
        tests_run++;
        if (value !== want) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, value, want);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a falling data_oe_n or chain output is one result; empty queue never matches
    always @(negedge clock) begin
        if ((data_oe_p === 1'b1 && data_oe_n === 1'b0) ||
            (iackout_p === 1'b1 && iackout_n === 1'b0)) begin
            got = (data_oe_n === 1'b0) ? {3'h0, data_o} : PASS_ON;
            check(got, (exp_q.size() > 0) ? exp_q.pop_front() : {11{1'bx}});
        end
        data_oe_p = data_oe_n;
        iackout_p = iackout_n;
    end

    // hang guard: 20,000 cycles, far beyond the ~500 the sequence needs
    initial begin
        #400000;
        fails++;
        close_out();
    end

    // =====================================================================
    // main sequence
    initial begin
        void'($urandom(32'hA02B));
        repeat (10) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clock);
        check({irq_oe_n, iackout_n, dtack_oe_n, data_oe_n, data_driver_enable_n},
              11'h7FF);
        // every level: pass-on for an idle port, vector, then no second answer
        for (int lvl = 1; lvl <= 7; lvl++) begin
            #1;
            prio_a = level_t'(lvl);
            prio_b = level_t'(lvl % 7 + 1);
            status_id_a = 8'($urandom);
            status_id_b = 8'($urandom);
            int_a = 1'b1;
            repeat (4) @(posedge clock);
            check({4'h0, irq_oe_n}, {4'h0, ~(7'h01 << (lvl - 1))});
            exp_q.push_back(PASS_ON);
            bus.ack_cycle(prio_b, 0, acked, early);
            check({9'h0, acked, iackout_n}, 11'h001);
            exp_q.push_back({3'h0, status_id_a});
            bus.ack_cycle(level_t'(lvl), $urandom_range(5, 0), acked, early);
            check({9'h0, acked, early}, 11'h002);
            check({4'h0, irq_oe_n}, 11'h07F);
            exp_q.push_back(PASS_ON);
            bus.ack_cycle(level_t'(lvl), 0, acked, early);
            check({4'h0, irq_oe_n, acked, iackout_n}, 11'h1FD);
            #1 int_a = 1'b0; // handler reads the status register
            repeat (3) @(posedge clock);
        end
        // equal priority: port A answers first, then port B
        #1;
        prio_a = 3'h5;
        prio_b = 3'h5;
        {int_a, int_b} = 2'b11;
        repeat (4) @(posedge clock);
        check({4'h0, irq_oe_n}, 11'h06F);
        check({3'h0, irq_o, dtack_o}, 11'h000);
        exp_q.push_back({3'h0, status_id_a});
        bus.ack_cycle(3'h5, 2, acked, early);
        exp_q.push_back({3'h0, status_id_b});
        bus.ack_cycle(3'h5, 2, acked, early);
        check({4'h0, irq_oe_n}, 11'h07F);
        #1 {int_a, int_b} = 2'b00;
        // read/write acknowledge: DTACK holds while the data driver is still on
        {rw_ack_n, rw_den_n} = 2'b00;
        repeat (4) @(posedge clock);
        check({9'h0, dtack_oe_n, data_driver_enable_n}, 11'h000);
        #1 rw_ack_n = 1'b1;
        repeat (4) @(posedge clock);
        check({10'h0, dtack_oe_n}, 11'h000);
        #1 rw_den_n = 1'b1;
        repeat (4) @(posedge clock);
        check({9'h0, dtack_oe_n, data_driver_enable_n}, 11'h003);
        check(11'(exp_q.size()), 11'h000);
        close_out();
    end
endmodule
